// [src/fxu_regs.vh]
`ifndef FXU_REGS_VH
`define FXU_REGS_VH

// ****************************************
// Operation codes
// ****************************************
`define OP_MUL_LOW        2'h0
`define OP_MUL_ALIAS      2'h1
`define OP_NEG_ABS        2'h2
`define OP_NAND           2'h3

// ****************************************
// Register offsets
// ****************************************
`define ADDR_CTRL         8'h00
`define ADDR_STATUS       8'h04
`define ADDR_MASK         8'h08
`define ADDR_FLAGS        8'h0C
`define ADDR_COND         8'h10
`define ADDR_RESULT       8'h14
`define ADDR_COUNT        8'h18

// ****************************************
// Field positions
// ****************************************
`define CTRL_ENABLE_BIT   0
`define EVT_DONE_BIT      0
`define EVT_OVF_BIT       1
`define EVT_DROP_BIT      2
`define FLAG_CARRY_BIT    0
`define FLAG_OVF_BIT      1
`define FLAG_SUMOVF_BIT   2
`define COND_SO_BIT       0
`define COND_EQ_BIT       1
`define COND_GT_BIT       2
`define COND_LT_BIT       3

// ****************************************
// Reset values
// ****************************************
`define CTRL_RESET        1'h1
`define STATUS_RESET      3'h0
`define MASK_RESET        3'h0
`define FLAGS_RESET       3'h0
`define COND_RESET        4'h0
`define WORD_RESET        32'h00000000

`endif

// [src/mul_low_word.v]
`timescale 1ns/1ps

// ****************************************
// Signed multiply, low word and overflow
// ****************************************
module mul_low_word #(
  parameter WIDTH = 32
) (
  input  wire [WIDTH-1:0] factor_a_i,
  input  wire [WIDTH-1:0] factor_b_i,
  output wire [WIDTH-1:0] low_o,
  output wire             overflow_o
);

  // Full double-width signed product
  wire signed [2*WIDTH-1:0] product;
  assign product = $signed(factor_a_i) * $signed(factor_b_i);

  assign low_o = product[WIDTH-1:0];

  assign overflow_o = (product[2*WIDTH-1:WIDTH] != {WIDTH{product[WIDTH-1]}});

endmodule // mul_low_word

// [src/fixed_point_mul_nabs_nand_unit.v]
`timescale 1ns/1ps
`include "fxu_regs.vh"

module fixed_point_mul_nabs_nand_unit #(
  parameter COUNT_WIDTH = 16
) (
  input  wire        clk_i,
  input  wire        rst_b_i,
  // Issue side
  input  wire        op_valid_i,
  input  wire [1:0]  op_code_i,
  input  wire        overflow_enable_i,
  input  wire        record_flag_i,
  input  wire [4:0]  target_field_i,
  input  wire [4:0]  first_reg_field_i,
  input  wire [31:0] first_reg_value_i,
  input  wire [31:0] second_source_reg_i,
  input  wire [31:0] first_source_reg_i,
  // Result side
  output reg         result_valid_o,
  output reg  [4:0]  result_index_o,
  output reg  [31:0] result_data_o,
  output reg         cond_valid_o,
  output reg  [3:0]  condition_field_zero_o,
  output reg         carry_flag_o,
  output reg         overflow_flag_o,
  output reg         summary_overflow_o,
  // Register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_write_i,
  input  wire        reg_read_i,
  output reg  [31:0] reg_rdata_o,
  output reg         irq_o
);

  // ****************************************
  // Functions
  // ****************************************

  // Signed compare with zero plus summary copy
  function [3:0] cond_of;
    input [31:0] value;
    input        so;
    reg   [3:0]  c;
    begin
      c = 4'h0;
      if (value[31]) begin
        c[`COND_LT_BIT] = 1'b1;
      end else if (value == 32'h00000000) begin
        c[`COND_EQ_BIT] = 1'b1;
      end else begin
        c[`COND_GT_BIT] = 1'b1;
      end
      c[`COND_SO_BIT] = so;
      cond_of = c;
    end
  endfunction

  // Register offset match
  function addr_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg                   enable_reg;
  reg                   enable_next;
  reg  [2:0]            status_reg;
  reg  [2:0]            status_next;
  reg  [2:0]            mask_reg;
  reg  [2:0]            mask_next;
  reg  [2:0]            flags_reg;
  reg  [2:0]            flags_next;
  reg  [3:0]            cond_reg;
  reg  [3:0]            cond_next;
  reg  [31:0]           result_reg;
  reg  [31:0]           result_next;
  reg  [COUNT_WIDTH-1:0] count_reg;
  reg  [COUNT_WIDTH-1:0] count_next;
  reg  [31:0]           rdata_next;

  // Register port decodes
  wire                  wr_ctrl;
  wire                  wr_mask;
  wire                  wr_flags;
  wire                  wr_count;
  wire                  rd_status;

  // Register words as read, spare bits zero
  wire [31:0]           ctrl_word;
  wire [31:0]           status_word;
  wire [31:0]           mask_word;
  wire [31:0]           flags_word;
  wire [31:0]           cond_word;
  wire [31:0]           count_word;

  // Datapath signals
  wire [31:0]           mul_low;
  wire                  mul_ovf;
  reg  [31:0]           neg_abs;
  reg  [31:0]           op_result;
  reg  [4:0]            op_index;
  reg  [2:0]            op_flags;
  reg                   op_ovf_event;
  reg  [2:0]            sw_flags;
  reg  [2:0]            events;
  wire                  op_take;
  wire                  op_drop;

  // Operation accepted only while enabled
  assign op_take = op_valid_i & enable_reg;
  assign op_drop = op_valid_i & ~enable_reg;

  // One decode per register strobe
  assign wr_ctrl   = reg_write_i & addr_hit(reg_addr_i, `ADDR_CTRL);
  assign wr_mask   = reg_write_i & addr_hit(reg_addr_i, `ADDR_MASK);
  assign wr_flags  = reg_write_i & addr_hit(reg_addr_i, `ADDR_FLAGS);
  assign wr_count  = reg_write_i & addr_hit(reg_addr_i, `ADDR_COUNT);
  assign rd_status = reg_read_i & addr_hit(reg_addr_i, `ADDR_STATUS);

  // Narrow fields sit in the low bits
  assign ctrl_word   = {{31{1'b0}}, enable_reg};
  assign status_word = {{29{1'b0}}, status_reg};
  assign mask_word   = {{29{1'b0}}, mask_reg};
  assign flags_word  = {{29{1'b0}}, flags_reg};
  assign cond_word   = {{28{1'b0}}, cond_reg};
  assign count_word  = {{(32-COUNT_WIDTH){1'b0}}, count_reg};

  // ****************************************
  // Multiplier
  // ****************************************
  mul_low_word #(
    .WIDTH (32)
  ) u_mul (
    .factor_a_i (first_reg_value_i),
    .factor_b_i (second_source_reg_i),
    .low_o      (mul_low),
    .overflow_o (mul_ovf)
  );

  // ****************************************
  // Operation datapath
  // ****************************************

  // Negative absolute value
  always @* begin
    if (first_reg_value_i[31]) begin
      neg_abs = first_reg_value_i;
    end else begin
      neg_abs = ~first_reg_value_i + 32'h00000001;
    end
  end

  // Flags as seen after a software write
  always @* begin
    sw_flags = flags_reg;
    if (wr_flags) begin
      sw_flags = reg_wdata_i[2:0];
    end
  end

  // Result, destination and flag update per operation
  always @* begin
    op_result    = `WORD_RESET;
    op_index     = target_field_i;
    op_flags     = sw_flags;
    op_ovf_event = 1'b0;
    case (op_code_i)
      `OP_MUL_LOW, `OP_MUL_ALIAS: begin
        op_result = mul_low;
        if (overflow_enable_i) begin
          op_flags[`FLAG_OVF_BIT] = mul_ovf;
          if (mul_ovf) begin
            op_flags[`FLAG_SUMOVF_BIT] = 1'b1;
          end
          op_ovf_event = mul_ovf;
        end
      end
      `OP_NEG_ABS: begin
        op_result = neg_abs;
        if (overflow_enable_i) begin
          op_flags[`FLAG_OVF_BIT] = 1'b0;
        end
      end
      `OP_NAND: begin
        // complement of AND into first register field
        op_result = ~(first_source_reg_i & second_source_reg_i);
        op_index  = first_reg_field_i;
        op_flags  = sw_flags;
      end
      default: begin
        op_result = `WORD_RESET;
      end
    endcase
  end

  // ****************************************
  // Next state of the register file
  // ****************************************

  // Control, mask and counter
  always @* begin
    enable_next = enable_reg;
    mask_next   = mask_reg;
    count_next  = count_reg;
    if (wr_ctrl) begin
      enable_next = reg_wdata_i[`CTRL_ENABLE_BIT];
    end
    if (wr_mask) begin
      mask_next = reg_wdata_i[2:0];
    end
    if (wr_count) begin
      count_next = {COUNT_WIDTH{1'b0}};
    end else if (op_take) begin
      count_next = count_reg + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Exception flags, condition field and last result
  always @* begin
    flags_next  = sw_flags;
    cond_next   = cond_reg;
    result_next = result_reg;
    if (op_take) begin
      flags_next  = op_flags;
      result_next = op_result;
      if (record_flag_i) begin
        cond_next = cond_of(op_result, op_flags[`FLAG_SUMOVF_BIT]);
      end
    end
  end

  // Sticky events, read clears, set wins
  always @* begin
    events = 3'h0;
    events[`EVT_DONE_BIT] = op_take;
    events[`EVT_OVF_BIT]  = op_take & op_ovf_event;
    events[`EVT_DROP_BIT] = op_drop;
    status_next = status_reg;
    if (rd_status) begin
      status_next = 3'h0;
    end
    status_next = status_next | events;
  end

  // Read data mux, unmapped reads zero
  always @* begin
    rdata_next = 32'h00000000;
    if (reg_read_i) begin
      case (reg_addr_i)
        `ADDR_CTRL:   rdata_next = ctrl_word;
        `ADDR_STATUS: rdata_next = status_word;
        `ADDR_MASK:   rdata_next = mask_word;
        `ADDR_FLAGS:  rdata_next = flags_word;
        `ADDR_COND:   rdata_next = cond_word;
        `ADDR_RESULT: rdata_next = result_reg;
        `ADDR_COUNT:  rdata_next = count_word;
        default:      rdata_next = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // State flip-flops
  // ****************************************
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable_reg  <= `CTRL_RESET;
      status_reg  <= `STATUS_RESET;
      mask_reg    <= `MASK_RESET;
      flags_reg   <= `FLAGS_RESET;
      cond_reg    <= `COND_RESET;
      result_reg  <= `WORD_RESET;
      count_reg   <= {COUNT_WIDTH{1'b0}};
    end else begin
      enable_reg  <= enable_next;
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      flags_reg   <= flags_next;
      cond_reg    <= cond_next;
      result_reg  <= result_next;
      count_reg   <= count_next;
    end
  end

  // ****************************************
  // Output flip-flops
  // ****************************************

  // Result write back and flag outputs
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_valid_o         <= 1'b0;
      result_index_o         <= 5'h00;
      result_data_o          <= `WORD_RESET;
      cond_valid_o           <= 1'b0;
      condition_field_zero_o <= `COND_RESET;
      carry_flag_o           <= 1'b0;
      overflow_flag_o        <= 1'b0;
      summary_overflow_o     <= 1'b0;
    end else begin
      result_valid_o         <= op_take;
      result_index_o         <= op_take ? op_index : 5'h00;
      result_data_o          <= op_take ? op_result : `WORD_RESET;
      cond_valid_o           <= op_take & record_flag_i;
      condition_field_zero_o <= cond_next;
      carry_flag_o           <= flags_next[`FLAG_CARRY_BIT];
      overflow_flag_o        <= flags_next[`FLAG_OVF_BIT];
      summary_overflow_o     <= flags_next[`FLAG_SUMOVF_BIT];
    end
  end

  // Register read data and interrupt
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h00000000;
      irq_o       <= 1'b0;
    end else begin
      reg_rdata_o <= rdata_next;
      irq_o       <= |(status_next & mask_next);
    end
  end

endmodule // fixed_point_mul_nabs_nand_unit

// [tb/gpr_file_model.sv]
`timescale 1ns/1ps

// ****************************************
// Register file seen by the issue side
// ****************************************
module gpr_file_model (
  input  wire        clk_i,
  input  wire [4:0]  a_idx_i,
  input  wire [4:0]  b_idx_i,
  input  wire [4:0]  s_idx_i,
  input  wire        wr_en_i,
  input  wire [4:0]  wr_idx_i,
  input  wire [31:0] wr_data_i,
  output wire [31:0] a_val_o,
  output wire [31:0] b_val_o,
  output wire [31:0] s_val_o
);
  reg [31:0] mem [0:31];
  integer    k;
  // Entries 0-3 hold fixed corner values
  initial begin
    for (k = 4; k < 32; k = k + 1) mem[k] = k * 32'h9E3779B9;
    mem[0] = 32'h80000000;
    mem[1] = 32'h00000000;
    mem[2] = 32'h7FFFFFFF;
    mem[3] = 32'hFFFFFFFF;
  end
  // Write back results, corners stay put
  always @(posedge clk_i) if (wr_en_i && wr_idx_i > 5'h03) mem[wr_idx_i] <= wr_data_i;
  assign a_val_o = mem[a_idx_i];
  assign b_val_o = mem[b_idx_i];
  assign s_val_o = mem[s_idx_i];
endmodule // gpr_file_model

// [tb/fxu_checker_asserts.sv]
`timescale 1ns/1ps

module fxu_checker (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire        op_valid_i,
  input wire [1:0]  op_code_i,
  input wire        overflow_enable_i,
  input wire        record_flag_i,
  input wire [4:0]  first_reg_field_i,
  input wire [31:0] first_reg_value_i,
  input wire [31:0] second_source_reg_i,
  input wire [31:0] first_source_reg_i,
  input wire        reg_write_i,
  input wire        result_valid_o,
  input wire [4:0]  result_index_o,
  input wire [31:0] result_data_o,
  input wire        cond_valid_o,
  input wire [3:0]  condition_field_zero_o,
  input wire        carry_flag_o,
  input wire        overflow_flag_o,
  input wire        summary_overflow_o
);
  reg [31:0] a_q, b_q, s_q;
  reg [1:0]  code_q;
  reg        oe_q;
  reg [4:0]  f_q;
  // Operands of the op in flight
  always @(posedge clk_i) begin
    a_q    <= first_reg_value_i;
    b_q    <= second_source_reg_i;
    s_q    <= first_source_reg_i;
    code_q <= op_code_i;
    oe_q   <= overflow_enable_i;
    f_q    <= first_reg_field_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_no_spurious: assert property (result_valid_o |-> $past(op_valid_i))
    else $error("result without op");
  a_cond_record: assert property (result_valid_o |-> cond_valid_o == $past(record_flag_i))
    else $error("cond valid mismatch");
  a_mul_low: assert property (result_valid_o && code_q < 2 |-> result_data_o == a_q * b_q)
    else $error("multiply low word wrong");
  a_nabs_value: assert property (result_valid_o && code_q == 2 |->
    result_data_o == (a_q[31] ? a_q : -a_q)) else $error("negative absolute wrong");
  a_nabs_ov: assert property (result_valid_o && code_q == 2 && oe_q |-> !overflow_flag_o)
    else $error("overflow not cleared");
  a_nand_value: assert property (result_valid_o && code_q == 3 |->
    result_data_o == ~(s_q & b_q) && result_index_o == f_q) else $error("nand wrong");
  a_carry_kept: assert property (result_valid_o && !$past(reg_write_i) |-> $stable(carry_flag_o))
    else $error("carry changed by op");
  a_nand_flags: assert property (result_valid_o && code_q == 3 && !$past(reg_write_i) |->
    $stable({overflow_flag_o, summary_overflow_o})) else $error("nand touched flags");
  a_one_compare: assert property (cond_valid_o |-> $onehot(condition_field_zero_o[3:1]))
    else $error("compare bits not one hot");
  a_cond_so: assert property (cond_valid_o |-> condition_field_zero_o[0] == summary_overflow_o)
    else $error("summary copy wrong");
  a_sign_bits: assert property (cond_valid_o |-> condition_field_zero_o[3] == result_data_o[31]
    && condition_field_zero_o[1] == (result_data_o == 32'h0)) else $error("sign bits wrong");
  c_mul_ovf: cover property (result_valid_o && code_q < 2 && oe_q && overflow_flag_o);
  c_nabs_rec: cover property (cond_valid_o && code_q == 2);
  c_nand_rec: cover property (cond_valid_o && code_q == 3);
endmodule // fxu_checker

bind fixed_point_mul_nabs_nand_unit fxu_checker fxu_checker_i (.clk_i, .rst_b_i, .op_valid_i,
  .op_code_i, .overflow_enable_i, .record_flag_i, .first_reg_field_i, .first_reg_value_i,
  .second_source_reg_i, .first_source_reg_i, .reg_write_i, .result_valid_o, .result_index_o,
  .result_data_o, .cond_valid_o, .condition_field_zero_o, .carry_flag_o, .overflow_flag_o,
  .summary_overflow_o);

// [tb/tb.sv]
`timescale 1ns/1ps
`include "fxu_regs.vh"
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t %s", $time, m); end end

module tb;
  reg         clk, rst_b, opv, oe, rc, wr, rd, en_m, so_m, ov_m, ca_m, ev, ec, rp;
  reg  [1:0]  code;
  reg  [4:0]  tf, af, bf, ei;
  reg  [7:0]  addr;
  reg  [31:0] wd, seed, ed, rx, last_m;
  reg  [2:0]  st_m, mk_m;
  reg  [3:0]  cond_m;
  reg  [15:0] cnt_m;
  wire [31:0] va, vb, vs, rdt, rdata;
  wire [4:0]  ri;
  wire [3:0]  cf;
  wire        rv, cv, ca, ov, so, irq;
  int         error_cnt, check_count, cyc;

  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  gpr_file_model gpr_file_model_i (.clk_i(clk), .a_idx_i(af), .b_idx_i(bf), .s_idx_i(tf),
    .wr_en_i(rv), .wr_idx_i(ri), .wr_data_i(rdt), .a_val_o(va), .b_val_o(vb), .s_val_o(vs));
  fixed_point_mul_nabs_nand_unit fixed_point_mul_nabs_nand_unit_i (.clk_i(clk), .rst_b_i(rst_b),
    .op_valid_i(opv), .op_code_i(code), .overflow_enable_i(oe), .record_flag_i(rc),
    .target_field_i(tf), .first_reg_field_i(af), .first_reg_value_i(va),
    .second_source_reg_i(vb), .first_source_reg_i(vs), .result_valid_o(rv),
    .result_index_o(ri), .result_data_o(rdt), .cond_valid_o(cv), .condition_field_zero_o(cf),
    .carry_flag_o(ca), .overflow_flag_o(ov), .summary_overflow_o(so), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .irq_o(irq));

  // Behavioural model, fed at each sampling edge
  always @(posedge clk or negedge rst_b) begin : mdl
    reg [63:0] p;
    reg [31:0] r;
    reg        f, ok;
    if (!rst_b) begin
      {en_m, so_m, ov_m, ca_m, ev, ec, rp} = 7'h40;
      {st_m, mk_m, cnt_m, last_m, cond_m} = 0;
    end else begin
      rp = rd;
      case (addr)
        `ADDR_CTRL: rx = {31'h0, en_m};
        `ADDR_STATUS: rx = {29'h0, st_m};
        `ADDR_MASK: rx = {29'h0, mk_m};
        `ADDR_FLAGS: rx = {29'h0, so_m, ov_m, ca_m};
        `ADDR_COND: rx = {28'h0, cond_m};
        `ADDR_RESULT: rx = last_m;
        `ADDR_COUNT: rx = {16'h0, cnt_m};
        default: rx = 32'h0;
      endcase
      ok = en_m;
      if (rd && addr == `ADDR_STATUS) st_m = 3'h0;
      if (wr && addr == `ADDR_CTRL) en_m = wd[0];
      if (wr && addr == `ADDR_MASK) mk_m = wd[2:0];
      if (wr && addr == `ADDR_FLAGS) {so_m, ov_m, ca_m} = wd[2:0];
      ev = opv && ok;
      ec = ev && rc;
      if (opv && !ok) st_m[2] = 1'b1;
      if (ev) begin
        p = $signed(va) * $signed(vb);
        r = code == `OP_NEG_ABS ? (va[31] ? va : -va) : code == `OP_NAND ? ~(vs & vb) : p[31:0];
        f = code < 2 && p[63:31] != {33{p[31]}};
        if (oe && code < 2) {so_m, ov_m} = {so_m | f, f};
        if (oe && code == `OP_NEG_ABS) ov_m = 1'b0;
        st_m = st_m | {1'b0, oe && f, 1'b1};
        ei = code == `OP_NAND ? af : tf;
        ed = r;
        last_m = r;
        cnt_m = cnt_m + 16'h1;
        if (rc) cond_m = {r[31], !r[31] && r != 0, r == 0, so_m};
      end
      if (wr && addr == `ADDR_COUNT) cnt_m = 16'h0;
    end
  end

  // Compare once the edge has settled
  always @(negedge clk) if (rst_b) begin
    `CHK(rv, ev, "result valid")
    `CHK({ri, rdt}, ev ? {ei, ed} : 37'h0, "result")
    `CHK(cv, ec, "cond valid")
    `CHK(cf, cond_m, "cond field")
    `CHK({so, ov, ca}, {so_m, ov_m, ca_m}, "flags")
    `CHK(irq, |(st_m & mk_m), "irq")
    `CHK(rdata, rp ? rx : 32'h0, "read data")
  end

  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  // Random ops with register traffic mixed in
  initial begin
    {rst_b, opv, code, oe, rc, tf, af, bf, addr, wd, wr, rd} = 0;
    seed = 32'hE2254320;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4000) begin
      @(posedge clk);
      seed = xs(seed);
      opv <= seed[0] | seed[1];
      code <= seed[3:2];
      oe <= seed[4];
      rc <= seed[5];
      tf <= seed[10:6];
      af <= seed[15:11];
      bf <= seed[20:16];
      wr <= seed[24:22] == 3'h0;
      rd <= seed[24:22] == 1;
      addr <= {3'h0, seed[28:26], 2'h0};
      wd <= {29'h0, seed[31:30], seed[25] | seed[29]};
    end
    @(posedge clk);
    {opv, wr, rd} <= 3'h0;
    repeat (3) @(posedge clk);
    report_and_stop;
  end
endmodule // tb
